// ===== hw/melody_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module melody_ctrl_regs
  import melody_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire note_status_t note,
  input wire logic melody_tone,
  input wire logic buzzer_signal,
  output logic tone_out_pin,
  output logic tone_out_n_pin,
  output logic play_busy,
  output logic [7:0] play_addr,
  output logic [4:0] play_tempo_div,
  output logic irq
);

  logic [7:0] play_start_addr_q;
  logic [3:0] tempo_code_q;
  logic play_mode_sel_q;
  logic output_source_sel_q;
  logic play_control_q;
  logic [1:0] completion_irq_priority_q;
  logic completion_irq_enable_q;
  logic completion_irq_flag_q;
  logic start_q;
  logic play_done;
  play_setup_t setup;
  play_setup_t active;

  logic access;
  logic wr_en;
  logic hit_prio;
  logic hit_en;
  logic hit_flag;
  logic hit_start;
  logic hit_ctrl;
  logic mapped;
  logic [7:0] rd_byte;

  assign access = apb_req.psel && apb_req.penable;
  assign wr_en = access && pready && apb_req.pwrite;
  assign hit_prio = apb_req.paddr == reg_addr(IDX_PRIO);
  assign hit_en = apb_req.paddr == reg_addr(IDX_IRQ_EN);
  assign hit_flag = apb_req.paddr == reg_addr(IDX_IRQ_FLAG);
  assign hit_start = apb_req.paddr == reg_addr(IDX_START);
  assign hit_ctrl = apb_req.paddr == reg_addr(IDX_CTRL);
  assign mapped = hit_prio || hit_en || hit_flag || hit_start || hit_ctrl;

  // Read mux; unused bits read zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit_start) begin
      rd_byte = play_start_addr_q;
    end
    if (hit_ctrl) begin
      rd_byte[CTRL_TEMPO_LSB +: 4] = tempo_code_q;
      rd_byte[CTRL_MODE_BIT] = play_mode_sel_q;
      rd_byte[CTRL_OSEL_BIT] = output_source_sel_q;
      rd_byte[CTRL_BUSY_BIT] = play_busy;
      rd_byte[CTRL_RUN_BIT] = play_control_q;
    end
    if (hit_prio) begin
      rd_byte[PRIO_LSB +: 2] = completion_irq_priority_q;
    end
    if (hit_en) begin
      rd_byte[IRQ_BIT] = completion_irq_enable_q;
    end
    if (hit_flag) begin
      rd_byte[IRQ_BIT] = completion_irq_flag_q;
    end
  end

  // One wait state keeps the read data registered
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      prdata <= {24'h00_0000, rd_byte};
      pslverr <= access && !pready && !mapped;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      play_start_addr_q <= START_RST;
    end else if (wr_en && hit_start) begin
      play_start_addr_q <= apb_req.pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tempo_code_q <= TEMPO_RST;
      play_mode_sel_q <= 1'b0;
      output_source_sel_q <= 1'b0;
      play_control_q <= 1'b0;
    end else if (wr_en && hit_ctrl) begin
      tempo_code_q <= apb_req.pwdata[CTRL_TEMPO_LSB +: 4];
      play_mode_sel_q <= apb_req.pwdata[CTRL_MODE_BIT];
      output_source_sel_q <= apb_req.pwdata[CTRL_OSEL_BIT];
      play_control_q <= apb_req.pwdata[CTRL_RUN_BIT];
    end
  end

  // Start one cycle late so a write that sets tempo and play together
  // hands the new tempo to the sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wr_en && hit_ctrl && apb_req.pwdata[CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      completion_irq_priority_q <= PRIO_RST;
    end else if (wr_en && hit_prio) begin
      completion_irq_priority_q <= apb_req.pwdata[PRIO_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      completion_irq_enable_q <= 1'b0;
    end else if (wr_en && hit_en) begin
      completion_irq_enable_q <= apb_req.pwdata[IRQ_BIT];
    end
  end

  // A completion in the clearing cycle is kept
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      completion_irq_flag_q <= 1'b0;
    end else if (play_done) begin
      completion_irq_flag_q <= 1'b1;
    end else if (wr_en && hit_flag && apb_req.pwdata[IRQ_BIT]) begin
      completion_irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= completion_irq_flag_q && completion_irq_enable_q
        && (completion_irq_priority_q != 2'h0);
    end
  end

  // Both pins follow the selected source, tone_out_n_pin inverted; buzzer silence passes through
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tone_out_pin <= 1'b0;
      tone_out_n_pin <= 1'b1;
    end else begin
      tone_out_pin <= output_source_sel_q ? melody_tone : buzzer_signal;
      tone_out_n_pin <= output_source_sel_q ? !melody_tone : !buzzer_signal;
    end
  end

  assign setup = '{start_addr: play_start_addr_q, tempo: tempo_code_q};

  melody_play_seq i_melody_play_seq (
    .sys_clk(sys_clk),
    .reset(reset),
    .start_req(start_q),
    .run_ctl(play_control_q),
    .one_shot(play_mode_sel_q),
    .setup(setup),
    .note(note),
    .busy(play_busy),
    .done(play_done),
    .active(active)
  );

  assign play_addr = active.start_addr;

  // Decoded on the start edge so the ratio leaves from a register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      play_tempo_div <= tempo_div(TEMPO_RST);
    end else if (start_q && !play_busy) begin
      play_tempo_div <= tempo_div(tempo_code_q);
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_start_addr_write: assert property (
    wr_en && hit_start |=> play_start_addr_q == $past(apb_req.pwdata[7:0]))
    else $error("Start address not stored");

  a_tempo_code_write: assert property (
    wr_en && hit_ctrl |=> tempo_code_q == $past(apb_req.pwdata[7:4]))
    else $error("Tempo code not stored");

  a_mode_sel_write: assert property (
    wr_en && hit_ctrl |=> play_mode_sel_q == $past(apb_req.pwdata[3]))
    else $error("Play mode not stored");

  a_pin_source_mux: assert property (
    ##1 tone_out_pin == ($past(output_source_sel_q) ? $past(melody_tone)
      : $past(buzzer_signal)) && tone_out_n_pin == !tone_out_pin)
    else $error("Output pin source wrong");

  a_busy_read_back: assert property (
    access && !pready && hit_ctrl |=> pready && prdata[1] == $past(play_busy))
    else $error("Busy status read wrong");

  a_play_start_req: assert property (
    wr_en && hit_ctrl && apb_req.pwdata[0] && !play_busy |=> ##1 play_busy)
    else $error("Play did not start");

  a_prio_write: assert property (
    wr_en && hit_prio |=> completion_irq_priority_q == $past(apb_req.pwdata[5:4]))
    else $error("Priority not stored");

  a_enable_write: assert property (
    wr_en && hit_en |=> completion_irq_enable_q == $past(apb_req.pwdata[6]))
    else $error("Enable not stored");

  a_flag_on_stop: assert property (
    $fell(play_busy) |=> completion_irq_flag_q)
    else $error("Completion flag not set");

  a_tempo_held_play: assert property (
    play_busy && $past(play_busy) |-> $stable(play_tempo_div) && $stable(play_addr))
    else $error("Tempo changed during play");

  a_oneshot_end_note: assert property (
    play_busy && play_mode_sel_q && note.done && note.end_mark
      |=> !play_busy && $stable(play_control_q))
    else $error("One-shot did not end at end note");

  a_level_hold_runs: assert property (
    play_busy && !play_mode_sel_q && play_control_q |=> play_busy)
    else $error("Level-hold play stopped early");

  a_busy_until_note: assert property (
    play_busy && !note.done |=> play_busy)
    else $error("Busy fell before note end");

  a_irq_gating: assert property (
    ##1 irq == ($past(completion_irq_flag_q) && $past(completion_irq_enable_q)
      && $past(completion_irq_priority_q) != 2'h0))
    else $error("Interrupt request gating wrong");

  a_tempo_div_decode: assert property (
    play_tempo_div == tempo_div(active.tempo))
    else $error("Tempo ratio does not match captured code");

  a_start_capture: assert property (
    $rose(play_busy) |-> play_addr == $past(play_start_addr_q)
      && play_tempo_div == tempo_div($past(tempo_code_q)))
    else $error("Play setup not captured at start");

  a_control_write: assert property (
    wr_en && hit_ctrl |=> play_control_q == $past(apb_req.pwdata[0]))
    else $error("Play control not stored");

  a_osel_write: assert property (
    wr_en && hit_ctrl |=> output_source_sel_q == $past(apb_req.pwdata[2]))
    else $error("Output select not stored");

  a_busy_rise_start: assert property (
    $rose(play_busy) |-> $past(start_q))
    else $error("Busy rose without a play start");

  a_stop_after_note: assert property (
    $fell(play_busy) |-> $past(note.done))
    else $error("Busy fell outside a note end");

  a_flag_set_wins: assert property (
    play_done |=> completion_irq_flag_q)
    else $error("Completion lost to a clear");

  a_flag_clear_write: assert property (
    wr_en && hit_flag && apb_req.pwdata[IRQ_BIT] && !play_done |=> !completion_irq_flag_q)
    else $error("Completion flag not cleared");

  a_irq_needs_prio: assert property (
    completion_irq_priority_q == 2'h0 |=> !irq)
    else $error("Interrupt raised at priority zero");

  a_one_wait_state: assert property (
    access && !pready |=> pready ##1 !pready)
    else $error("Bus answer not after one wait state");

  a_unmapped_slverr: assert property (
    access && !pready && !mapped |=> pready && pslverr)
    else $error("Unmapped access not refused");

  a_read_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h00_0000)
    else $error("Upper read bits not zero");

  c_play_started: cover property ($rose(play_busy));
  c_play_stopped: cover property ($fell(play_busy) ##1 completion_irq_flag_q);
  c_irq_raised: cover property ($rose(irq));
  c_flag_cleared: cover property (completion_irq_flag_q ##1 !completion_irq_flag_q);
  c_oneshot_end: cover property (play_busy && play_mode_sel_q && note.done && note.end_mark);

endmodule // melody_ctrl_regs
`default_nettype wire

// ===== common/melody_regs_pkg.sv
// Overview of operation
// - Read/write play start address, resets zero
// - Four-bit tempo code in control bits 7:4
// - Control bit 3 selects one-shot or level-hold
// - Control bit 2 selects melody or buzzer output
// - Control bit 1 reads busy status only
// - Control bit 0 requests play or stop
// - Two-bit completion priority in bits 5:4
// - Completion interrupt enable bit, resets zero
// - Flag sets on full stop; write one clears
// - Tempo captured at play start only
// - One-shot ends at end note; level-hold by control
// - Busy holds until current note finishes
package melody_regs_pkg;

  localparam int ADDR_W = 18;

  // Register indexes; the byte address is four times the index
  localparam logic [15:0] IDX_PRIO = 16'hff28;
  localparam logic [15:0] IDX_IRQ_EN = 16'hff2a;
  localparam logic [15:0] IDX_IRQ_FLAG = 16'hff2c;
  localparam logic [15:0] IDX_START = 16'hff46;
  localparam logic [15:0] IDX_CTRL = 16'hff47;

  localparam int CTRL_TEMPO_LSB = 4;
  localparam int CTRL_MODE_BIT = 3;
  localparam int CTRL_OSEL_BIT = 2;
  localparam int CTRL_BUSY_BIT = 1;
  localparam int CTRL_RUN_BIT = 0;
  localparam int PRIO_LSB = 4;
  localparam int IRQ_BIT = 6;

  localparam logic [7:0] START_RST = 8'h00;
  localparam logic [3:0] TEMPO_RST = 4'h0;
  localparam logic [1:0] PRIO_RST = 2'h0;
  localparam logic [4:0] TEMPO_DIV_TOP = 5'h10;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic done;
    logic end_mark;
  } note_status_t;

  typedef struct packed {
    logic [7:0] start_addr;
    logic [3:0] tempo;
  } play_setup_t;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  // Code 15 divides by 1, code 0 by 16
  function automatic logic [4:0] tempo_div(input logic [3:0] code);
    return TEMPO_DIV_TOP - {1'b0, code};
  endfunction

endpackage

// ===== hw/melody_play_seq.sv
`timescale 1ns/1ps
`default_nettype none
module melody_play_seq
  import melody_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic start_req,
  input wire logic run_ctl,
  input wire logic one_shot,
  input wire play_setup_t setup,
  input wire note_status_t note,
  output logic busy,
  output logic done,
  output play_setup_t active
);

  typedef enum logic [0:0] {ST_IDLE, ST_PLAY} seq_state_t;

  seq_state_t state_q;

  // A stop never cuts a note short, so the tone never clicks
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (start_req) begin
            state_q <= ST_PLAY;
            busy <= 1'b1;
          end
        end
        ST_PLAY: begin
          if (note.done && (!run_ctl || (one_shot && note.end_mark))) begin
            state_q <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      active <= '0;
    end else if (state_q == ST_IDLE && start_req) begin
      active <= setup;
    end
  end

endmodule // melody_play_seq
`default_nettype wire

// ===== verif/apb_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module apb_cpu_model
  import melody_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output var apb_req_t apb_req
);
  initial apb_req = '0;
  // Request held until pready is seen at a rising edge, then released
  task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    apb_req <= '0;
  endtask
endmodule // apb_cpu_model
`default_nettype wire

// ===== verif/melody_ctrl_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module melody_ctrl_regs_test;
  import melody_regs_pkg::*;
  localparam logic [17:0] A_PRIO = 18'h3fca0;
  localparam logic [17:0] A_EN = 18'h3fca8;
  localparam logic [17:0] A_FLAG = 18'h3fcb0;
  localparam logic [17:0] A_START = 18'h3fd18;
  localparam logic [17:0] A_CTRL = 18'h3fd1c;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  apb_req_t apb_req;
  note_status_t note = '0;
  logic melody_tone = 1'b1;
  logic buzzer_signal = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, tone_out_pin, tone_out_n_pin, play_busy, irq, er;
  logic [7:0] play_addr;
  logic [4:0] play_tempo_div;
  logic [31:0] rd;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;

  always #50 sys_clk = ~sys_clk;

  melody_ctrl_regs i_melody_ctrl_regs (.sys_clk(sys_clk), .reset(reset),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .note(note), .melody_tone(melody_tone), .buzzer_signal(buzzer_signal),
    .tone_out_pin(tone_out_pin), .tone_out_n_pin(tone_out_n_pin),
    .play_busy(play_busy), .play_addr(play_addr),
    .play_tempo_div(play_tempo_div), .irq(irq));

  apb_cpu_model i_apb_cpu_model (.sys_clk(sys_clk), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .apb_req(apb_req));

  task automatic finish_test;
    $display("Errors %0d, checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    i_apb_cpu_model.xfer(1'b1, a, {24'h0, d}, rd, er);
  endtask

  task automatic rdchk(input logic [17:0] a, input logic [7:0] e, input string what);
    i_apb_cpu_model.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, {24'h0, e}, what);
  endtask

  task automatic note_end(input logic em);
    note <= '{done: 1'b1, end_mark: em};
    @(posedge sys_clk);
    note <= '0;
  endtask

  task automatic wait_busy(input logic v);
    repeat (8) begin
      if (play_busy === v) break;
      @(posedge sys_clk);
    end
    chk(play_busy, v, "busy");
  endtask

  task automatic t_reset;
    rdchk(A_START, 8'h00, "start rst");
    rdchk(A_CTRL, 8'h00, "ctrl rst");
    rdchk(A_PRIO, 8'h00, "prio rst");
    rdchk(A_EN, 8'h00, "en rst");
    chk({irq, play_busy, tone_out_n_pin}, 3'b001, "pins rst");
  endtask

  task automatic t_rw;
    wr(A_START, 8'ha5);
    rdchk(A_START, 8'ha5, "start rw");
    wr(A_CTRL, 8'hfe);
    rdchk(A_CTRL, 8'hfc, "ctrl rw");
    chk({tone_out_pin, tone_out_n_pin}, 2'b10, "melody out");
    wr(A_CTRL, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk({tone_out_pin, tone_out_n_pin}, 2'b01, "buzzer out");
    wr(A_PRIO, 8'h30);
    rdchk(A_PRIO, 8'h30, "prio rw");
    wr(A_EN, 8'h40);
    rdchk(A_EN, 8'h40, "en rw");
    i_apb_cpu_model.xfer(1'b1, 18'h00010, 32'h0, rd, er);
    chk(er, 1'b1, "unmapped");
  endtask

  task automatic t_level;
    wr(A_PRIO, 8'h10);
    wr(A_CTRL, 8'hf1);
    wait_busy(1'b1);
    chk({play_addr, play_tempo_div}, {8'ha5, 5'd1}, "capture");
    wr(A_CTRL, 8'h01);
    note_end(1'b1);
    repeat (3) @(posedge sys_clk);
    chk({play_busy, play_tempo_div}, {1'b1, 5'd1}, "still play");
    wr(A_CTRL, 8'h00);
    repeat (3) @(posedge sys_clk);
    chk(play_busy, 1'b1, "busy hold");
    note_end(1'b0);
    wait_busy(1'b0);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b1, "irq on");
    rdchk(A_FLAG, 8'h40, "flag set");
    wr(A_FLAG, 8'h40);
    rdchk(A_FLAG, 8'h00, "flag clr");
    chk(irq, 1'b0, "irq off");
  endtask

  task automatic t_oneshot;
    wr(A_EN, 8'h00);
    wr(A_CTRL, 8'h09);
    wait_busy(1'b1);
    chk(play_tempo_div, 5'd16, "tempo 0");
    note_end(1'b0);
    repeat (2) @(posedge sys_clk);
    chk(play_busy, 1'b1, "no end");
    note_end(1'b1);
    wait_busy(1'b0);
    repeat (3) @(posedge sys_clk);
    rdchk(A_CTRL, 8'h09, "run kept");
    rdchk(A_FLAG, 8'h40, "flag masked");
    chk(irq, 1'b0, "irq masked");
    wr(A_EN, 8'h40);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b1, "irq enabled");
    wr(A_PRIO, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0, "prio zero");
  endtask

  // Cuts a hang short; the full run needs under two hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      $display("ERROR %0t timeout", $time);
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_rw();
    t_level();
    t_oneshot();
    finish_test();
  end
endmodule // melody_ctrl_regs_test
`default_nettype wire
